// [hw/cycle_stamp_unit.sv]
// cycle stamp counter, counter event control and two event counters
// assumes the core presents one instruction per cycle with its privilege level
`timescale 1ns/1ps
`include "cycle_stamp_defs.svh"
module cycle_stamp_unit
  import cycle_stamp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // instruction request from the core
  input wire logic req_valid,
  input access_req_t req,
  input wire logic stamp_disable_flag,
  input wire logic counter_read_enable_flag,
  // answer to the core
  output logic resp_valid,
  output answer_t resp_status,
  output logic [31:0] result_upper,
  output logic [31:0] result_lower,
  // event sources, one level per event number
  input wire logic [127:0] events,
  // monitor pins
  output logic monitor_pin_zero,
  output logic monitor_pin_one
);
  logic [63:0] cycle_stamp_counter;
  logic [63:0] counter_event_control;
  logic [47:0] count_zero;
  logic [47:0] count_one;
  logic level_zero;
  logic is_write;
  logic is_model_read;
  logic is_stamp_read;
  logic is_counter_read;
  logic write_ok;
  logic mapped;
  logic load_zero;
  logic load_one;
  counter_cfg_t cfg_zero;
  counter_cfg_t cfg_one;
  logic [63:0] next_read_data;
  answer_t next_status;
  logic gate_zero;
  logic gate_one;
  logic recognised;

  // instruction decode
  assign level_zero = (req.privilege == 2'h0);
  assign is_write = req_valid && req.opcode == `OP_MODEL_WRITE;
  assign is_model_read = req_valid && req.opcode == `OP_MODEL_READ;
  assign is_stamp_read = req_valid && req.opcode == `OP_STAMP_READ;
  assign is_counter_read = req_valid && req.opcode == `OP_COUNTER_READ;
  assign mapped = req.index >= `IDX_CYCLE_STAMP && req.index <= `IDX_EVENT_COUNTER_ONE;
  assign write_ok = is_write && level_zero && mapped;
  assign load_zero = write_ok && req.index == `IDX_EVENT_COUNTER_ZERO;
  assign load_one = write_ok && req.index == `IDX_EVENT_COUNTER_ONE;

  // per-counter fields of the control register
  assign cfg_zero.pin_overflow = counter_event_control[`BIT_PIN_ZERO];
  assign cfg_zero.count_clocks = counter_event_control[`BIT_TYPE_ZERO];
  assign cfg_zero.user_enable = counter_event_control[`BIT_USER_ZERO];
  assign cfg_zero.low_enable = counter_event_control[`BIT_LOW_ZERO];
  assign cfg_zero.event_select = {counter_event_control[`BIT_SEL_HI_ZERO],
    counter_event_control[`SEL_LO_ZERO +: 6]};
  assign cfg_one.pin_overflow = counter_event_control[`BIT_PIN_ONE];
  assign cfg_one.count_clocks = counter_event_control[`BIT_TYPE_ONE];
  assign cfg_one.user_enable = counter_event_control[`BIT_USER_ONE];
  assign cfg_one.low_enable = counter_event_control[`BIT_LOW_ONE];
  assign cfg_one.event_select = {counter_event_control[`BIT_SEL_HI_ONE],
    counter_event_control[`SEL_LO_ONE +: 6]};

  // terms shared by the checks: counting permission and any decoded instruction
  assign gate_zero = (req.privilege == `USER_LEVEL) ? cfg_zero.user_enable
    : cfg_zero.low_enable;
  assign gate_one = (req.privilege == `USER_LEVEL) ? cfg_one.user_enable
    : cfg_one.low_enable;
  assign recognised = is_stamp_read || is_model_read || is_write || is_counter_read;

  // stamp counter, free running on the core clock
  always_ff @(posedge clock) begin
    if (reset) begin
      cycle_stamp_counter <= `RESET_STAMP;
    end else if (write_ok && req.index == `IDX_CYCLE_STAMP) begin
      cycle_stamp_counter <= req.data;
    end else begin
      cycle_stamp_counter <= cycle_stamp_counter + 64'h0000_0000_0000_0001;
    end
  end

  // control register, reserved bits held at zero
  always_ff @(posedge clock) begin
    if (reset) begin
      counter_event_control <= `RESET_CONTROL;
    end else if (write_ok && req.index == `IDX_EVENT_CONTROL) begin
      counter_event_control <= req.data & `CONTROL_MASK;
    end
  end

  // the two counters, one slice each
  event_counter_slice counter_zero (
    .clock(clock),
    .reset(reset),
    .cfg(cfg_zero),
    .privilege(req.privilege),
    .events(events),
    .load(load_zero),
    .load_value(req.data[47:0]),
    .count(count_zero),
    .monitor_pin(monitor_pin_zero)
  );
  event_counter_slice counter_one (
    .clock(clock),
    .reset(reset),
    .cfg(cfg_one),
    .privilege(req.privilege),
    .events(events),
    .load(load_one),
    .load_value(req.data[47:0]),
    .count(count_one),
    .monitor_pin(monitor_pin_one)
  );

  // read data and permission selection
  always_comb begin
    next_read_data = 64'h0000_0000_0000_0000;
    next_status = answer_ok;
    if (is_stamp_read) begin
      if (stamp_disable_flag && !level_zero) begin
        next_status = answer_fault;
      end else begin
        next_read_data = cycle_stamp_counter;
      end
    end else if (is_model_read || is_write) begin
      if (!level_zero) begin
        next_status = answer_fault;
      end else if (!mapped) begin
        next_status = answer_unmapped;
      end else if (is_model_read) begin
        case (req.index)
          `IDX_CYCLE_STAMP: next_read_data = cycle_stamp_counter;
          `IDX_EVENT_CONTROL: next_read_data = counter_event_control;
          `IDX_EVENT_COUNTER_ZERO: next_read_data = {16'h0000, count_zero};
          default: next_read_data = {16'h0000, count_one};
        endcase
      end
    end else if (is_counter_read) begin
      if (!counter_read_enable_flag && !level_zero) begin
        next_status = answer_fault;
      end else if (req.index[31:1] != 31'h0000_0000) begin
        next_status = answer_unmapped;
      end else begin
        next_read_data = {16'h0000, req.index[0] ? count_one : count_zero};
      end
    end
  end

  // answer registers, one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp_status <= answer_ok;
      result_upper <= 32'h0000_0000;
      result_lower <= 32'h0000_0000;
    end else begin
      resp_valid <= is_stamp_read || is_model_read || is_write || is_counter_read;
      resp_status <= next_status;
      result_upper <= next_read_data[63:32];
      result_lower <= next_read_data[31:0];
    end
  end

  stamp_steps_a: assert property (@(posedge clock) disable iff (reset)
    !(write_ok && req.index == `IDX_CYCLE_STAMP) |=>
      cycle_stamp_counter == $past(cycle_stamp_counter) + 64'h0000_0000_0000_0001)
    else $error("stamp did not step");
  stamp_guard_a: assert property (@(posedge clock) disable iff (reset)
    (is_stamp_read && stamp_disable_flag && !level_zero) |=> resp_status == answer_fault)
    else $error("stamp read not refused");
  stamp_value_a: assert property (@(posedge clock) disable iff (reset)
    (is_stamp_read && !stamp_disable_flag) |=>
      {result_upper, result_lower} == $past(cycle_stamp_counter))
    else $error("stamp read wrong");
  write_guard_a: assert property (@(posedge clock) disable iff (reset)
    (is_write && !level_zero && req.index == `IDX_EVENT_CONTROL) |=> $stable(counter_event_control))
    else $error("unprivileged write took effect");
  control_write_a: assert property (@(posedge clock) disable iff (reset)
    (write_ok && req.index == `IDX_EVENT_CONTROL) |=>
      counter_event_control == ($past(req.data) & `CONTROL_MASK))
    else $error("control write lost");
  preset_load_a: assert property (@(posedge clock) disable iff (reset)
    load_zero |=> count_zero == $past(req.data[47:0]))
    else $error("preset not loaded");
  counter_guard_a: assert property (@(posedge clock) disable iff (reset)
    (is_counter_read && !counter_read_enable_flag && !level_zero) |=> resp_status == answer_fault)
    else $error("counter read not refused");
  model_read_a: assert property (@(posedge clock) disable iff (reset)
    (is_model_read && level_zero && req.index == `IDX_EVENT_CONTROL) |=>
      result_lower == $past(counter_event_control[31:0]))
    else $error("control readback wrong");
  reset_clear_a: assert property (@(posedge clock)
    reset |=> counter_event_control == `RESET_CONTROL && count_one == `RESET_COUNT)
    else $error("reset did not clear");

  // every decoded instruction answers on the next cycle
  resp_pulse_a: assert property (@(posedge clock) disable iff (reset)
    recognised
    |=> resp_valid)
    else $error("answer pulse missing");

  // no answer without an instruction
  resp_idle_a: assert property (@(posedge clock) disable iff (reset)
    !recognised
    |=> !resp_valid)
    else $error("answer without instruction");

  // unprivileged model read is refused and returns nothing
  read_guard_a: assert property (@(posedge clock) disable iff (reset)
    (is_model_read && !level_zero)
    |=> (resp_status == answer_fault && {result_upper, result_lower} == 64'h0000_0000_0000_0000))
    else $error("unprivileged read served");

  // unprivileged model write is refused
  write_refused_a: assert property (@(posedge clock) disable iff (reset)
    (is_write && !level_zero)
    |=> resp_status == answer_fault)
    else $error("unprivileged write not refused");

  // indices outside the four registers are reported
  unmapped_index_a: assert property (@(posedge clock) disable iff (reset)
    (is_model_read && level_zero && !mapped)
    |=> resp_status == answer_unmapped)
    else $error("unmapped index served");

  // level 0 may always read the stamp
  stamp_allow_a: assert property (@(posedge clock) disable iff (reset)
    (is_stamp_read && level_zero)
    |=> resp_status == answer_ok)
    else $error("stamp read refused at level 0");

  // a stamp write replaces the count
  stamp_write_a: assert property (@(posedge clock) disable iff (reset)
    (write_ok && req.index == `IDX_CYCLE_STAMP)
    |=> cycle_stamp_counter == $past(req.data))
    else $error("stamp preset lost");

  // model read of the stamp returns the whole count
  stamp_readback_a: assert property (@(posedge clock) disable iff (reset)
    (is_model_read && level_zero && req.index == `IDX_CYCLE_STAMP)
    |=> {result_upper, result_lower} == $past(cycle_stamp_counter))
    else $error("stamp readback wrong");

  // model read of the control register, upper half
  control_upper_a: assert property (@(posedge clock) disable iff (reset)
    (is_model_read && level_zero && req.index == `IDX_EVENT_CONTROL)
    |=> result_upper == $past(counter_event_control[63:32]))
    else $error("control upper half wrong");

  // enabled counter read of counter one at any level
  counter_allow_a: assert property (@(posedge clock) disable iff (reset)
    (is_counter_read && counter_read_enable_flag && req.index == 32'h0000_0001)
    |=> resp_status == answer_ok
      && {result_upper, result_lower} == {16'h0000, $past(count_one)})
    else $error("counter read wrongly refused");

  // level 0 reads counter zero whatever the enable flag
  counter_zero_read_a: assert property (@(posedge clock) disable iff (reset)
    (is_counter_read && level_zero && req.index == 32'h0000_0000)
    |=> {result_upper, result_lower} == {16'h0000, $past(count_zero)})
    else $error("counter zero read wrong");

  // counter read beyond counter one is reported
  counter_unmapped_a: assert property (@(posedge clock) disable iff (reset)
    (is_counter_read && level_zero && req.index > 32'h0000_0001)
    |=> resp_status == answer_unmapped)
    else $error("counter index not refused");

  // a write to counter one replaces its count
  preset_one_a: assert property (@(posedge clock) disable iff (reset)
    load_one
    |=> count_one == $past(req.data[47:0]))
    else $error("counter one preset lost");

  // timer mode adds one per permitted cycle, counter zero
  timer_zero_a: assert property (@(posedge clock) disable iff (reset)
    (cfg_zero.count_clocks && gate_zero && !load_zero)
    |=> count_zero == $past(count_zero) + 48'h0000_0000_0001)
    else $error("counter zero timer missed a cycle");

  // timer mode adds one per permitted cycle, counter one
  timer_one_a: assert property (@(posedge clock) disable iff (reset)
    (cfg_one.count_clocks && gate_one && !load_one)
    |=> count_one == $past(count_one) + 48'h0000_0000_0001)
    else $error("counter one timer missed a cycle");

  // event mode adds one per cycle with the selected event
  event_count_zero_a: assert property (@(posedge clock) disable iff (reset)
    (gate_zero && events[cfg_zero.event_select] && !load_zero)
    |=> count_zero == $past(count_zero) + 48'h0000_0000_0001)
    else $error("counter zero missed an event");

  // event indicator follows every counted cycle, pin zero
  event_pin_zero_a: assert property (@(posedge clock) disable iff (reset)
    (!cfg_zero.pin_overflow && gate_zero && events[cfg_zero.event_select] && !load_zero)
    |=> monitor_pin_zero)
    else $error("event pin zero missed");

  // event indicator follows every counted cycle, pin one
  event_pin_one_a: assert property (@(posedge clock) disable iff (reset)
    (!cfg_one.pin_overflow && gate_one && events[cfg_one.event_select] && !load_one)
    |=> monitor_pin_one)
    else $error("event pin one missed");

  // a gated counter keeps its pin low
  pin_quiet_zero_a: assert property (@(posedge clock) disable iff (reset)
    !gate_zero
    |=> !monitor_pin_zero)
    else $error("pin zero active while gated");

  // overflow indicator stays low until the count wraps
  overflow_one_a: assert property (@(posedge clock) disable iff (reset)
    (cfg_one.pin_overflow && count_one != 48'hFFFF_FFFF_FFFF)
    |=> !monitor_pin_one)
    else $error("overflow pin one without wrap");

  stamp_read_c: cover property (@(posedge clock) is_stamp_read && !reset);
  overflow_c: cover property (@(posedge clock) monitor_pin_one && cfg_one.pin_overflow);
  counter_read_c: cover property (@(posedge clock) is_counter_read && resp_valid);
  event_pin_c: cover property (@(posedge clock) monitor_pin_zero && !cfg_zero.pin_overflow);
  unmapped_c: cover property (@(posedge clock) resp_valid && resp_status == answer_unmapped);
endmodule

// [include/cycle_stamp_defs.svh]
// register indices, control field positions and opcodes for the counting unit
// assumes inclusion by bare name from the design files and the bench
`ifndef CYCLE_STAMP_DEFS_SVH
`define CYCLE_STAMP_DEFS_SVH
`define IDX_CYCLE_STAMP 32'h0000_0010
`define IDX_EVENT_CONTROL 32'h0000_0011
`define IDX_EVENT_COUNTER_ZERO 32'h0000_0012
`define IDX_EVENT_COUNTER_ONE 32'h0000_0013
`define OP_MODEL_WRITE 16'h0F30
`define OP_STAMP_READ 16'h0F31
`define OP_MODEL_READ 16'h0F32
`define OP_COUNTER_READ 16'h0F33
`define RESET_CONTROL 64'h0000_0000_0000_0000
`define RESET_COUNT 48'h0000_0000_0000
`define RESET_STAMP 64'h0000_0000_0000_0000
`define BIT_SEL_HI_ONE 26
`define BIT_PIN_ONE 25
`define BIT_TYPE_ONE 24
`define BIT_USER_ONE 23
`define BIT_LOW_ONE 22
`define SEL_LO_ONE 16
`define BIT_SEL_HI_ZERO 10
`define BIT_PIN_ZERO 9
`define BIT_TYPE_ZERO 8
`define BIT_USER_ZERO 7
`define BIT_LOW_ZERO 6
`define SEL_LO_ZERO 0
`define CONTROL_MASK 64'h0000_0000_07FF_07FF
`define USER_LEVEL 2'h3
`endif

// [include/cycle_stamp_pkg.sv]
// types shared by the counting unit and its event counter slices
// assumes cycle_stamp_defs.svh is on the include path
package cycle_stamp_pkg;
  typedef struct packed {
    logic [15:0] opcode;
    logic [31:0] index;
    logic [63:0] data;
    logic [1:0] privilege;
  } access_req_t;

  typedef struct packed {
    logic pin_overflow;
    logic count_clocks;
    logic user_enable;
    logic low_enable;
    logic [6:0] event_select;
  } counter_cfg_t;

  typedef enum logic [1:0] {
    answer_ok,
    answer_fault,
    answer_unmapped
  } answer_t;
endpackage

// [hw/event_counter_slice.sv]
// one 48-bit event counter with its monitor pin logic
// assumes 128 event levels on the core clock, config from the control register
`timescale 1ns/1ps
`include "cycle_stamp_defs.svh"
module event_counter_slice
  import cycle_stamp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration and privilege
  input counter_cfg_t cfg,
  input wire logic [1:0] privilege,
  input wire logic [127:0] events,
  // software preset
  input wire logic load,
  input wire logic [47:0] load_value,
  // results
  output logic [47:0] count,
  output logic monitor_pin
);
  logic level_ok;
  logic hit;
  logic step;
  logic [48:0] sum;

  // privilege gating and source select
  assign level_ok = (privilege == `USER_LEVEL) ? cfg.user_enable : cfg.low_enable;
  assign hit = cfg.count_clocks ? 1'b1 : events[cfg.event_select];
  assign step = level_ok && hit;
  assign sum = {1'b0, count} + 49'h0_0000_0000_0001;

  // counter, written value wins over increment
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= `RESET_COUNT;
    end else if (load) begin
      count <= load_value;
    end else if (step) begin
      count <= sum[47:0];
    end
  end

  // pin shows events per cycle or a wrap of the counter
  always_ff @(posedge clock) begin
    if (reset) begin
      monitor_pin <= 1'b0;
    end else if (cfg.pin_overflow) begin
      monitor_pin <= step && !load && sum[48];
    end else begin
      monitor_pin <= step && !load;
    end
  end

  pin_wrap_a: assert property (@(posedge clock) disable iff (reset)
    (cfg.pin_overflow && step && !load && count == 48'hFFFF_FFFF_FFFF) |=> monitor_pin)
    else $error("overflow not flagged");
  no_gate_a: assert property (@(posedge clock) disable iff (reset)
    (!level_ok && !load) |=> $stable(count))
    else $error("counted while gated");
endmodule

// [verification/core_model.sv]
// core model: issues one instruction at a time to the counting unit
// assumes the unit's clock and a registered answer one cycle after the request
`timescale 1ns/1ps
module core_model
  import cycle_stamp_pkg::*;
(
  // clock
  input wire logic clock,
  // request side
  output logic req_valid,
  output access_req_t req,
  // answer side
  input wire logic resp_valid,
  input answer_t resp_status,
  input wire logic [31:0] result_upper,
  input wire logic [31:0] result_lower
);
  // idle request at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one instruction; privilege stays as the current level after it
  task automatic issue(input logic [15:0] op, input logic [31:0] idx, input logic [63:0] data,
    input logic [1:0] priv, output answer_t st, output logic [63:0] res, output logic seen);
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req = '{opcode: op, index: idx, data: data, privilege: priv};
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    seen = resp_valid;
    st = resp_status;
    res = {result_upper, result_lower};
    // released fields no longer show the last value
    req.data = ~data;
    req.index = ~idx;
  endtask
endmodule

// [verification/tb_cycle_stamp_unit.sv]
// self-checking bench for the counting unit, core model as requester
// assumes a 100 MHz clock and synchronous active-high reset
`timescale 1ns/1ps
`include "cycle_stamp_defs.svh"
module tb_cycle_stamp_unit;
  import cycle_stamp_pkg::*;
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] idx;
    logic [63:0] data;
    logic [1:0] priv;
    logic sdis;
    logic read_en;
    answer_t st;
    logic chk;
    logic [63:0] res;
  } row_t;
  logic clock;
  logic reset;
  logic req_valid;
  access_req_t req;
  logic stamp_disable_flag;
  logic counter_read_enable_flag;
  logic resp_valid;
  answer_t resp_status;
  logic [31:0] result_upper;
  logic [31:0] result_lower;
  logic [127:0] events;
  logic monitor_pin_zero;
  logic monitor_pin_one;
  answer_t st;
  logic [63:0] res;
  logic seen;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_pin0 = 0;
  int n_pin1 = 0;
  int pin_base;
  // ordinary accesses: request beside expected answer
  row_t rows [10] = '{
    '{`OP_MODEL_WRITE, `IDX_EVENT_CONTROL, 64'hFFFF_FFFF_F83F_F83F, 2'h0, 0, 0, answer_ok, 1, 64'h0},
    '{`OP_MODEL_READ, `IDX_EVENT_CONTROL, 64'h0, 2'h0, 0, 0, answer_ok, 1, 64'h003F_003F},
    '{`OP_MODEL_WRITE, `IDX_EVENT_CONTROL, 64'h0, 2'h3, 0, 0, answer_fault, 1, 64'h0},
    '{`OP_MODEL_READ, `IDX_EVENT_CONTROL, 64'h0, 2'h0, 0, 0, answer_ok, 1, 64'h003F_003F},
    '{`OP_MODEL_READ, `IDX_EVENT_CONTROL, 64'h0, 2'h1, 0, 0, answer_fault, 1, 64'h0},
    '{`OP_MODEL_READ, 32'h0000_0014, 64'h0, 2'h0, 0, 0, answer_unmapped, 1, 64'h0},
    '{`OP_STAMP_READ, 32'h0, 64'h0, 2'h3, 1, 0, answer_fault, 1, 64'h0},
    '{`OP_STAMP_READ, 32'h0, 64'h0, 2'h3, 0, 0, answer_ok, 0, 64'h0},
    '{`OP_COUNTER_READ, 32'h0, 64'h0, 2'h3, 0, 0, answer_fault, 1, 64'h0},
    '{`OP_COUNTER_READ, 32'h1, 64'h0, 2'h3, 0, 1, answer_ok, 1, 64'h0}
  };

  // design and its requester
  cycle_stamp_unit uut (.clock(clock), .reset(reset), .req_valid(req_valid), .req(req),
    .stamp_disable_flag(stamp_disable_flag), .counter_read_enable_flag(counter_read_enable_flag),
    .resp_valid(resp_valid), .resp_status(resp_status), .result_upper(result_upper),
    .result_lower(result_lower), .events(events), .monitor_pin_zero(monitor_pin_zero),
    .monitor_pin_one(monitor_pin_one));
  core_model core (.clock(clock), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp_status(resp_status), .result_upper(result_upper), .result_lower(result_lower));

  // clock
  always #5 clock = ~clock;

  // pin activity counts and hang limit
  always @(posedge clock) begin
    cycles++;
    if (monitor_pin_zero === 1'b1) n_pin0++;
    if (monitor_pin_one === 1'b1) n_pin1++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // compare one value
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one instruction through the core model
  task automatic access(input logic [15:0] op, input logic [31:0] idx, input logic [63:0] data,
    input logic [1:0] priv);
    core.issue(op, idx, data, priv, st, res, seen);
    check("resp_valid", 64'h1, 64'(seen));
  endtask

  // hold one event level for k cycles
  task automatic pulse(input int n, input int k);
    @(posedge clock);
    #1;
    events[n] = 1'b1;
    repeat (k) @(posedge clock);
    #1;
    events = '0;
    repeat (2) @(posedge clock);
  endtask

  // verdict
  task automatic finish_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    events = '0;
    stamp_disable_flag = 1'b0;
    counter_read_enable_flag = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset = 1'b0;
    foreach (rows[i]) begin
      stamp_disable_flag = rows[i].sdis;
      counter_read_enable_flag = rows[i].read_en;
      access(rows[i].op, rows[i].idx, rows[i].data, rows[i].priv);
      check("status", 64'(rows[i].st), 64'(st));
      if (rows[i].chk) check("result", rows[i].res, res);
    end
    counter_read_enable_flag = 1'b0;
    // stamp preset near the top, then wrap of the 64-bit count
    access(`OP_MODEL_WRITE, `IDX_CYCLE_STAMP, 64'hFFFF_FFFF_FFFF_FFFE, 2'h0);
    access(`OP_STAMP_READ, 32'h0, 64'h0, 2'h0);
    check("stamp", 64'hFFFF_FFFF_FFFF_FFFF, res);
    access(`OP_STAMP_READ, 32'h0, 64'h0, 2'h0);
    check("stamp_wrap", 64'h1, res);
    // second reset in mid-run clears control and restarts the stamp
    reset = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    reset = 1'b0;
    access(`OP_MODEL_READ, `IDX_EVENT_CONTROL, 64'h0, 2'h0);
    check("control", 64'h0, res);
    access(`OP_STAMP_READ, 32'h0, 64'h0, 2'h0);
    check("stamp_small", 64'h3, res);
    // counter one as timer with overflow pin, preset one below wrap
    access(`OP_MODEL_WRITE, `IDX_EVENT_CONTROL, 64'h03C0_0000, 2'h0);
    pin_base = n_pin1;
    access(`OP_MODEL_WRITE, `IDX_EVENT_COUNTER_ONE, 64'hFFFF_FFFF_FFFF, 2'h0);
    access(`OP_COUNTER_READ, 32'h1, 64'h0, 2'h0);
    check("timer_wrap", 64'h0, res);
    repeat (4) @(posedge clock);
    check("overflow_pin", 64'h1, 64'(n_pin1 - pin_base));
    // counter zero on event 45h, enabled below level 3 only
    access(`OP_MODEL_WRITE, `IDX_EVENT_CONTROL, 64'h0445, 2'h0);
    access(`OP_MODEL_READ, `IDX_EVENT_CONTROL, 64'h0, 2'h3);
    pulse(69, 3);
    access(`OP_COUNTER_READ, 32'h0, 64'h0, 2'h0);
    check("gated_count", 64'h0, res);
    pin_base = n_pin0;
    pulse(69, 3);
    access(`OP_COUNTER_READ, 32'h0, 64'h0, 2'h0);
    check("event_count", 64'h3, res);
    check("event_pin", 64'h3, 64'(n_pin0 - pin_base));
    // counter one on event 45h, selector high bit in bit 26
    access(`OP_MODEL_WRITE, `IDX_EVENT_CONTROL, 64'h0445_0000, 2'h0);
    access(`OP_MODEL_WRITE, `IDX_EVENT_COUNTER_ONE, 64'h0, 2'h0);
    pin_base = n_pin1;
    pulse(69, 2);
    access(`OP_COUNTER_READ, 32'h1, 64'h0, 2'h0);
    check("event_count_one", 64'h2, res);
    check("event_pin_one", 64'h2, 64'(n_pin1 - pin_base));
    finish_test();
  end
endmodule
